/* rtl/rcsl_params.svh */
// constants of the remote command serial link: timing counts and preset values
`ifndef RCSL_PARAMS_SVH
`define RCSL_PARAMS_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define RCSL_CLK_PERIOD_NS    50

// ----------------------------------------------------------------
// timing figures and their cycle counts
// ----------------------------------------------------------------
`define RCSL_SAMPLE_PERIOD_NS 500000
`define RCSL_SAMPLE_CYCLES    (`RCSL_SAMPLE_PERIOD_NS / `RCSL_CLK_PERIOD_NS)
`define RCSL_GATE_PERIOD_NS   2000
`define RCSL_GATE_CYCLES      (`RCSL_GATE_PERIOD_NS / `RCSL_CLK_PERIOD_NS)
`define RCSL_SLOT_NS          1000
`define RCSL_SLOT_CYCLES      (`RCSL_SLOT_NS / `RCSL_CLK_PERIOD_NS)
`define RCSL_UPDATE_CYCLES    (`RCSL_GATE_CYCLES * 8)

// ----------------------------------------------------------------
// counter and word layout
// ----------------------------------------------------------------
`define RCSL_CNT_PRESET       4'h8
`define RCSL_CNT_RUN_BIT      3
`define RCSL_SLOTS            4'h8
`define RCSL_LAST_SLOT        4'h7
`define RCSL_LATCH_RESET      8'h00

`endif

/* rtl/rcsl_pkg.sv */
// types shared by the remote command serial link
`default_nettype none
package rcsl_pkg;

    // command word: bit i travels in slot i
    typedef struct packed {
        logic range_msb;
        logic range_mid;
        logic range_lsb;
        logic autorange;
        logic ext_ref;
        logic filter;
        logic func_n;
        logic func_r;
    } rcsl_cmd_t;

    // whole state of the link
    typedef struct packed {
        logic [1:0]  sync1;
        logic [1:0]  sync2;
        rcsl_cmd_t   cmd_sync1;
        rcsl_cmd_t   cmd_sync2;
        logic        entry_prev;
        logic [15:0] osc_cnt;
        logic [3:0]  cnt;
        logic [5:0]  ph;
        logic        ch_one;
        logic        ch_zero;
        logic        pulse_prev;
        logic [7:0]  sr;
        logic [3:0]  rx_cnt;
        rcsl_cmd_t   latch;
    } rcsl_state_t;

endpackage
`default_nettype wire

/* rtl/rcsl_link.sv */
// remote command serial link: sample timing, serialiser, receiver and decoder
// What this block does
// - continuous mode refreshes commands at 2 kHz
// - each sample pulse presets counter, starts sequence
// - inhibit low selects triggered mode, stops oscillator
// - each trigger pulse while idle starts exactly one update; a pulse while busy is ignored
// - multiplexer routes one input by address
// - eight slots per update, one microsecond each
// - ones on one channel, zeros on other
// - shift register collects slots, then holds
// - latch blocked while shift register loads
// - latch takes word after all eight bits
// - decoders restore original command line format
// - resistance functions force external reference off
// - set pulse presets counter to top bit
// - gated clock steps eight states, stops at zero
`timescale 1ns/100ps
`default_nettype none
`include "rcsl_params.svh"

module rcsl_link
    import rcsl_pkg::*;
#(
    parameter int SAMPLE_CYCLES = `RCSL_SAMPLE_CYCLES
) (
    // clock and reset
    input  wire logic      sys_clk_in,
    input  wire logic      reset_n_in,
    // command lines from the external equipment
    input  wire rcsl_cmd_t cmd_in,
    input  wire logic      free_run_inhibit_in,
    input  wire logic      ext_entry_in,
    // isolated pulse channels
    output logic           ch_one_out,
    output logic           ch_zero_out,
    // status
    output logic           busy_out,
    output logic           loading_out,
    // decoded command lines toward the instrument
    output rcsl_cmd_t      cmd_out
);

    // ----------------------------------------------------------------
    // constants
    // ----------------------------------------------------------------
    localparam logic [15:0] OSC_LAST  = 16'(SAMPLE_CYCLES - 1);
    localparam logic [5:0]  GATE_LAST = 6'(`RCSL_GATE_CYCLES - 1);
    localparam logic [5:0]  SLOT_LEN  = 6'(`RCSL_SLOT_CYCLES);

    rcsl_state_t s_q;
    rcsl_state_t s_d;

    logic       run;
    logic       free_run;
    logic       osc_fire;
    logic       trig;
    logic       set_req;
    logic       mux_bit;
    logic       any_pulse;
    logic       shift_ev;
    logic [7:0] sr_next;

    // picks the command bit for a slot address
    function automatic logic mux_pick(input rcsl_cmd_t c, input logic [2:0] a);
        logic [7:0] w;
        w = c;
        mux_pick = w[a];
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // derived terms read the second sync stage only
    always_comb begin
        run       = s_q.cnt[`RCSL_CNT_RUN_BIT];
        free_run  = s_q.sync2[1];
        osc_fire  = free_run && (s_q.osc_cnt == OSC_LAST);
        trig      = !free_run && s_q.entry_prev && !s_q.sync2[0];
        set_req   = (osc_fire || trig) && !run;
        mux_bit   = mux_pick(s_q.cmd_sync2, s_q.cnt[2:0]);
        any_pulse = s_q.ch_one || s_q.ch_zero;
        shift_ev  = any_pulse && !s_q.pulse_prev;
        sr_next   = {s_q.ch_one, s_q.sr[7:1]};
    end

    // one copy of the whole state, filled in one place
    always_comb begin
        s_d            = s_q;
        s_d.sync1      = {free_run_inhibit_in, ext_entry_in};
        s_d.sync2      = s_q.sync1;
        s_d.entry_prev = s_q.sync2[0];
        // command lines are levels changed between updates, so syncing the word whole is safe
        s_d.cmd_sync1  = cmd_in;
        s_d.cmd_sync2  = s_q.cmd_sync1;
        // sample oscillator only runs while not inhibited
        if (!free_run) begin
            s_d.osc_cnt = 16'h0000;
        end else if (osc_fire) begin
            s_d.osc_cnt = 16'h0000;
        end else begin
            s_d.osc_cnt = s_q.osc_cnt + 16'h0001;
        end
        // set pulse presets the counter and frees the gated clock
        if (set_req) begin
            s_d.cnt    = `RCSL_CNT_PRESET;
            s_d.ph     = 6'h00;
            s_d.rx_cnt = 4'h0;
        end else if (run) begin
            if (s_q.ph == GATE_LAST) begin
                s_d.ph  = 6'h00;
                s_d.cnt = s_q.cnt + 4'h1;
            end else begin
                s_d.ph  = s_q.ph + 6'h01;
            end
        end
        // first half of every gate period carries the slot pulse
        s_d.ch_one  = run && (s_q.ph < SLOT_LEN) && mux_bit;
        s_d.ch_zero = run && (s_q.ph < SLOT_LEN) && !mux_bit;
        s_d.pulse_prev = any_pulse;
        // receiver: the latch stays shut until the eighth bit lands
        if (shift_ev) begin
            s_d.sr = sr_next;
            if (s_q.rx_cnt == `RCSL_LAST_SLOT) begin
                s_d.rx_cnt = 4'h0;
                s_d.latch  = sr_next;
                s_d.latch.ext_ref = sr_next[3] && !sr_next[1];
            end else begin
                s_d.rx_cnt = s_q.rx_cnt + 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // async reset leaves the link idle with a cleared latch
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_q       <= '0;
            s_q.latch <= `RCSL_LATCH_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops, handshake-like status from decode
    assign ch_one_out  = s_q.ch_one;
    assign ch_zero_out = s_q.ch_zero;
    assign cmd_out     = s_q.latch;
    assign busy_out    = run;
    assign loading_out = (s_q.rx_cnt != 4'h0);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    // a set pulse always lands the counter on its preset
    AST_SET_PRESET: assert property (set_req |=> s_q.cnt == 4'h8 && s_q.ph == 6'h00)
        else $error("set pulse did not preset the counter");

    // the last state rolls into zero and stays there
    AST_STOP_AT_ZERO: assert property (
        s_q.cnt == 4'hf && s_q.ph == 6'd39 |=> s_q.cnt == 4'h0
            ##1 (s_q.cnt == 4'h0 || $past(set_req)))
        else $error("counter did not stop at zero");

    // an idle counter only leaves zero on a set pulse
    AST_IDLE_HOLD: assert property (s_q.cnt == 4'h0 && !set_req |=> s_q.cnt == 4'h0)
        else $error("idle counter moved without a set pulse");

    // never both channels at once
    AST_ONE_CHANNEL: assert property (!(ch_one_out && ch_zero_out))
        else $error("both pulse channels active");

    // a slot pulse lasts exactly one microsecond
    AST_SLOT_WIDTH: assert property (
        $rose(ch_one_out || ch_zero_out) |-> ##19 (ch_one_out || ch_zero_out)
            ##1 !(ch_one_out || ch_zero_out))
        else $error("slot pulse width wrong");

    // the one channel follows the addressed command bit
    AST_MUX_ROUTE: assert property (ch_one_out |-> $past(mux_bit))
        else $error("one pulse without a one on the addressed input");

    // helper count of busy cycles: a whole update is too long for a plain delay
    localparam logic [8:0] BUSY_LEN = 9'(`RCSL_UPDATE_CYCLES);
    logic [8:0] ast_busy_len_q;

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ast_busy_len_q <= 9'h000;
        end else if (busy_out) begin
            ast_busy_len_q <= ast_busy_len_q + 9'h001;
        end else begin
            ast_busy_len_q <= 9'h000;
        end
    end

    // a whole update takes eight gate periods
    AST_EIGHT_SLOTS: assert property ($fell(busy_out) |-> ast_busy_len_q == BUSY_LEN)
        else $error("update length wrong");

    // busy never outlasts eight gate periods
    AST_BUSY_BOUND: assert property (busy_out |-> ast_busy_len_q < BUSY_LEN)
        else $error("update ran past eight gate periods");

    // latch holds still while the shift register loads
    AST_LATCH_BLOCKED: assert property (loading_out && !shift_ev |=> $stable(cmd_out))
        else $error("latch changed during loading");

    // after the eighth bit the latch holds the received word
    AST_LATCH_LOAD: assert property (
        shift_ev && s_q.rx_cnt == 4'h7 |=> cmd_out[7:4] == $past(sr_next[7:4])
            && cmd_out[2:0] == $past(sr_next[2:0]) && !loading_out)
        else $error("latch did not take the full word");

    // resistance functions never show external reference
    AST_EXTREF_LOCK: assert property (cmd_out.func_n |-> !cmd_out.ext_ref)
        else $error("external reference with resistance function");

    // inhibit keeps the sample oscillator still
    AST_OSC_SUPPRESS: assert property (!free_run |=> s_q.osc_cnt == 16'h0000)
        else $error("sample oscillator ran while inhibited");

    // a request while busy does not restart the cycle
    AST_BUSY_IGNORE: assert property (
        run && (osc_fire || trig) && s_q.ph != 6'd39 |=> s_q.ph != 6'h00)
        else $error("busy cycle restarted");

endmodule
`default_nettype wire

/* bench/rcsl_ext_equipment.sv */
// model of the external equipment that drives the command and mode lines
`timescale 1ns/100ps
`default_nettype none
module rcsl_ext_equipment
    import rcsl_pkg::*;
(
    // clock
    input  wire logic sys_clk_in,
    // lines toward the link
    output rcsl_cmd_t cmd_out,
    output logic      free_run_inhibit_out,
    output logic      ext_entry_out
);
    // idle as if both mode lines were left open: continuous mode
    initial begin
        cmd_out = 8'h00;
        free_run_inhibit_out = 1'b1;
        ext_entry_out = 1'b1;
    end
    // command lines are sampled live, so callers change them only between updates
    task automatic set_cmd(input rcsl_cmd_t value);
        @(posedge sys_clk_in);
        #2;
        cmd_out = value;
    endtask
    // inhibit low selects triggered mode
    task automatic set_triggered(input logic on);
        @(posedge sys_clk_in);
        #2;
        free_run_inhibit_out = ~on;
    endtask
    // negative entry pulse, long enough to pass the two-stage synchroniser
    task automatic trigger();
        @(posedge sys_clk_in);
        #2;
        ext_entry_out = 1'b0;
        repeat (4) @(posedge sys_clk_in);
        #2;
        ext_entry_out = 1'b1;
    endtask
endmodule
`default_nettype wire

/* bench/rcsl_link_tb.sv */
// self-checking bench for the remote command serial link
`timescale 1ns/100ps
`default_nettype none
module rcsl_link_tb
    import rcsl_pkg::*;
;
    localparam int SAMPLE_CYCLES = 400; // shortened sample period, still above one update
    logic       sys_clk_in;
    logic       reset_n_in;
    rcsl_cmd_t  cmd;
    logic       inhibit;
    logic       entry;
    logic       ch_one;
    logic       ch_zero;
    logic       busy;
    logic       loading;
    rcsl_cmd_t  cmd_out;
    rcsl_cmd_t  prev;
    logic [7:0] words [4] = '{8'ha5, 8'h5a, 8'h0b, 8'hfc};
    int         fails;
    int         total_checks;
    int         n;

    rcsl_link #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) rcsl_link_i (.sys_clk_in(sys_clk_in),
        .reset_n_in(reset_n_in), .cmd_in(cmd), .free_run_inhibit_in(inhibit),
        .ext_entry_in(entry), .ch_one_out(ch_one), .ch_zero_out(ch_zero),
        .busy_out(busy), .loading_out(loading), .cmd_out(cmd_out));
    rcsl_ext_equipment rcsl_ext_equipment_i (.sys_clk_in(sys_clk_in), .cmd_out(cmd),
        .free_run_inhibit_out(inhibit), .ext_entry_out(entry));

    // ------------------------------------------------------------
    // clock and helpers
    // ------------------------------------------------------------
    initial begin
        sys_clk_in = 1'b0;
        forever #25 sys_clk_in = ~sys_clk_in;
    end
    // sample and drive a little after the edge so the design's updates have landed
    task automatic tick();
        @(posedge sys_clk_in);
        #2;
    endtask
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, got);
        end
    endtask
    // expected decoder output: resistance functions lock out the external reference
    function automatic rcsl_cmd_t decoded(input rcsl_cmd_t c);
        decoded = c;
        if (c.func_n) decoded.ext_ref = 1'b0;
    endfunction
    task automatic wait_busy(output int cnt);
        cnt = 0;
        while (busy !== 1'b1 && cnt < 2000) begin
            tick();
            cnt++;
        end
        check("busy_start", 8'h01, {7'h00, busy});
    endtask
    // busy seen high at the edge after the set request; slot i pulse spans c1+40i..c20+40i
    task automatic capture(input rcsl_cmd_t exp, input rcsl_cmd_t old);
        repeat (11) tick();
        for (int i = 0; i < 8; i++) begin
            check("slot_chan", {6'h00, exp[i], ~exp[i]}, {6'h00, ch_one, ch_zero});
            if (i < 7) begin
                check("loading", 8'h01, {7'h00, loading});
                check("held_out", old, cmd_out);
                repeat (20) tick();
                check("slot_gap", 8'h00, {6'h00, ch_one, ch_zero});
                repeat (20) tick();
            end
        end
        repeat (28) tick();
        check("busy_end", 8'h01, {7'h00, busy});
        tick();
        check("busy_off", 8'h00, {7'h00, busy});
        check("loaded", 8'h00, {7'h00, loading});
        check("cmd_out", decoded(exp), cmd_out);
    endtask
    task automatic expect_idle(input int cycles, input string name);
        int hits;
        hits = 0;
        repeat (cycles) begin
            tick();
            if (busy !== 1'b0) hits++;
        end
        check(name, 8'h00, (hits > 0) ? 8'h01 : 8'h00);
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        fails = 0;
        total_checks = 0;
        reset_n_in = 1'b0;
        prev = 8'h00;
        repeat (10) @(posedge sys_clk_in);
        #2;
        reset_n_in = 1'b1;
        check("reset_out", 8'h00, cmd_out);
        // continuous mode: every function code, lockout on and off
        for (int k = 0; k < 4; k++) begin
            rcsl_ext_equipment_i.set_cmd(words[k]);
            wait_busy(n);
            if (k > 0) check("period", 8'(SAMPLE_CYCLES - 321), 8'(n));
            capture(words[k], prev);
            prev = decoded(words[k]);
        end
        // triggered mode: oscillator silenced, one update for two entry pulses, the second sent while busy
        rcsl_ext_equipment_i.set_triggered(1'b1);
        expect_idle(2 * SAMPLE_CYCLES, "no_free_run");
        rcsl_ext_equipment_i.set_cmd(8'h3c);
        fork
            begin
                rcsl_ext_equipment_i.trigger();
                repeat (100) tick();
                rcsl_ext_equipment_i.trigger();
            end
            begin
                wait_busy(n);
                capture(8'h3c, prev);
            end
        join
        expect_idle(500, "busy_trigger_dropped");
        // reset in mid-update clears every output, and its release starts nothing
        rcsl_ext_equipment_i.trigger();
        wait_busy(n);
        repeat (50) tick();
        reset_n_in = 1'b0;
        tick();
        check("reset_busy", 8'h00, {7'h00, busy});
        check("reset_cmd", 8'h00, cmd_out);
        check("reset_link", 8'h00, {6'h00, loading, ch_one | ch_zero});
        reset_n_in = 1'b1;
        expect_idle(500, "no_start_after_reset");
        give_verdict();
    end

    // hang guard, well beyond the few thousand cycles the tests take
    initial begin
        repeat (10000) @(posedge sys_clk_in);
        fails++;
        $display("FAIL watchdog expected done seen hang");
        give_verdict();
    end
endmodule
`default_nettype wire
